/* File: shared/sac_pkg.sv */
// Shared constants, types and helper functions of the converter control block
package sac_pkg;
	localparam int SAR_W = 12;
	localparam int RES_W = 16;
	localparam int ID_W = 5;
	localparam int NFLAG = 10;
	localparam int ENTRY_W = RES_W + ID_W + 1;
	localparam int FIFO_DEPTH = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SGL_CTRL = 8'h04;
	localparam logic [7:0] OFS_SCN_CTRL = 8'h08;
	localparam logic [7:0] OFS_SCN_MASK = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_CMPTHR = 8'h1C;
	localparam logic [7:0] OFS_SGL_DATA = 8'h20;
	localparam logic [7:0] OFS_SCN_DATA = 8'h24;
	localparam logic [7:0] OFS_SCN_DATAX = 8'h28;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] MCTL_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = 32'h0000_0001;
	localparam logic [31:0] THR_RST = 32'hFFFF_0000;
	// Main control fields
	localparam int C_EN = 0;
	localparam int C_ENG = 1;
	localparam int C_POL = 2;
	localparam int C_WARM = 3;
	localparam int C_PRESCALE_FIELD = 5;
	localparam int C_TB = 12;
	localparam int C_OSR = 20;
	// Per-mode control fields
	localparam int M_REP = 0;
	localparam int M_DIFF = 1;
	localparam int M_OVS = 2;
	localparam int M_CMP = 3;
	localparam int M_RES = 4;
	localparam int M_LEFT = 6;
	localparam int M_OVWR = 7;
	localparam int M_ACQ = 8;
	localparam int M_DVL = 16;
	localparam int M_NEG = 18;
	localparam int M_POS = 23;
	// Command bits
	localparam int K_SGL_GO = 0;
	localparam int K_SCN_GO = 1;
	localparam int K_SGL_STOP = 2;
	localparam int K_SCN_STOP = 3;
	// Flag bits
	localparam int F_SGL_DV = 0;
	localparam int F_SCN_DV = 1;
	localparam int F_SGL_OVF = 2;
	localparam int F_SCN_OVF = 3;
	localparam int F_SGL_UNF = 4;
	localparam int F_SCN_UNF = 5;
	localparam int F_SGL_CMP = 6;
	localparam int F_SCN_CMP = 7;
	localparam int F_OVERV = 8;
	localparam int F_PROGERR = 9;
	// Warm-up periods of the warmup_a
	localparam logic [2:0] WARM_LONG = 3'h5;
	localparam logic [2:0] WARM_SHORT = 3'h1;
	localparam logic [11:0] SAR_MSB = 12'h800;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WARM = 3'b001,
		ST_ACQ = 3'b010,
		ST_APPROX = 3'b011,
		ST_STORE = 3'b100
	} sac_state_t;

	typedef enum logic [1:0] {
		WARM_NORMAL = 2'b00,
		WARM_STANDBY = 2'b01,
		WARM_SLOWACC = 2'b10,
		WARM_KEEP = 2'b11
	} sac_warm_t;

	// Resolution select to bit count
	function automatic logic [3:0] res_bits(input logic [1:0] sel);
		case (sel)
			2'b01: return 4'h8;
			2'b10: return 4'h6;
			default: return 4'hC;
		endcase
	endfunction

	// Lowest mask bit at or above from: {found, index}
	function automatic logic [5:0] next_chan(input logic [31:0] mask, input logic [5:0] from);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 31; i >= 0; i--) begin
			if (mask[i] && (6'(i) >= from)) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction
endpackage

/* File: core/sac_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module sac_sync import sac_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sac_sync_st_t;
	sac_sync_st_t r_q, r_d;

	// First stage feeds only the second
	always_comb begin
		r_d.s1 = d;
		r_d.s2 = r_q.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign q = r_q.s2;
endmodule

/* File: core/sac_fifo.sv */
// Result buffer with overwrite-or-discard on full
`timescale 1ns/1ps
module sac_fifo import sac_pkg::*; #(
	parameter int W = ENTRY_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic [W-1:0] din,
	input wire logic ovwr,
	input wire logic pop,
	output logic [W-1:0] head,
	output logic [$clog2(DEPTH):0] cnt,
	output logic ovf,
	output logic unf
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
		logic ovf;
		logic unf;
	} sac_fifo_st_t;
	sac_fifo_st_t r_q, r_d;
	logic full, do_pop, wr_en, drop;

	// Pointers wrap naturally, so DEPTH must be a power of two
	always_comb begin
		r_d = r_q;
		full = (r_q.cnt == (AW+1)'(DEPTH));
		do_pop = pop && (r_q.cnt != '0);
		wr_en = push && (!full || do_pop || ovwr);
		drop = push && full && !do_pop && ovwr;
		r_d.ovf = push && full && !do_pop;
		r_d.unf = pop && (r_q.cnt == '0);
		if (wr_en) begin
			r_d.mem[r_q.wr] = din;
			r_d.wr = r_q.wr + 1'b1;
		end
		if (do_pop || drop) begin
			r_d.rd = r_q.rd + 1'b1;
		end
		r_d.cnt = r_q.cnt + {{AW{1'b0}}, wr_en && !drop} - {{AW{1'b0}}, do_pop};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign head = r_q.mem[r_q.rd];
	assign cnt = r_q.cnt;
	assign ovf = r_q.ovf;
	assign unf = r_q.unf;
endmodule

/* File: core/sac_top.sv */
// Converter control: register slave, engine sequencer, prescaler, warm-up and result buffers
// Operation
// - All logic runs on the bus clock; the source clock is only sampled.
// - Registers, buffers, flags and the store step every bus clock; the rest of the sequencer, prescaler and warm-up on engine ticks.
// - Synchronous select makes the engine clock equal the bus clock.
// - Asynchronous select makes the engine tick on each sampled rising edge of the external source clock.
// - Prescaler divides engine clock by 1 to 128 for the conversion clock.
// - Conversion clock also times the acquisition phase.
// - Warm-up is counted in engine clock cycles, not conversion clock cycles.
// - On-demand policy with normal warm mode requests the clock only per conversion.
// - All other policy settings hold the clock request until reprogrammed or synchronous.
// - Resolution 6, 8 or 12 bits; 12-bit conversion takes 13 clocks.
// - Shared oversampling ratio 2 to 4096, per-mode enable, 16-bit results.
// - Each mode has a four-entry buffer that overwrites or discards on full.
// - Unread count reaching the watermark raises a flag and a DMA request.
// - Scan of up to 32 masked inputs, one-shot or repeating, tagged by channel.
// - A single conversion may run between two scan conversions.
// - Single-ended results straight binary, differential two's complement and sign-extended; left or right aligned.
// - Each mode flags window compare trips, buffer overflow and underflow.
// - Port conflict or illegal negative select flags a programming error; over-voltage flags.
// - Approximation takes one conversion clock per bit plus one.
// - When both compete, a pending single takes the slot right after each scan conversion.
// - The first conversion after enabling warms up for five warmup_a periods.
`timescale 1ns/1ps
module sac_top import sac_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic ASYNC_CLK_IN,
	input wire logic TRIG_SINGLE,
	input wire logic TRIG_SCAN,
	input wire logic ANA_CMP,
	input wire logic PORT_CONFLICT,
	input wire logic OVERVOLT,
	output logic ASYNC_CLK_REQ,
	output logic ANA_POWER,
	output logic ANA_SAMPLE,
	output logic ANA_DIFF,
	output logic [4:0] ANA_POS_SEL,
	output logic [4:0] ANA_NEG_SEL,
	output logic [11:0] SAR_TRIAL,
	output logic DMA_REQ_SINGLE,
	output logic DMA_REQ_SCAN
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] sctl;
		logic [31:0] cctl;
		logic [31:0] mask;
		logic [31:0] thr;
		logic [NFLAG-1:0] flags;
		logic [31:0] prdata;
		logic pslverr;
		logic aclk_prev;
		logic [6:0] prescale_field;
		logic [7:0] tb;
		logic [2:0] wper;
		logic warm_done;
		sac_state_t st;
		logic [7:0] acq;
		logic [3:0] bitc;
		logic [11:0] pos;
		logic [11:0] trial;
		logic cur_scan;
		logic [4:0] cur_chan;
		logic sgl_pend;
		logic scn_act;
		logic [4:0] scn_idx;
		logic last_scan;
		logic [23:0] acc;
		logic [11:0] ocnt;
		logic req;
		logic conf_prev;
		logic ov_prev;
		logic samp;
		logic power;
	} sac_top_st_t;
	sac_top_st_t r_q, r_d;

	logic aclk_s, eng_tick, sar_tick, en, wr_acc, rd_acc;
	logic sgl_pop, scn_pop, sgl_push, scn_push, sgl_trig, scn_trig, ovs_last, trip;
	logic [31:0] mc, jmc;
	logic [3:0] nbits;
	logic [4:0] osrsh, sh;
	logic [5:0] nx;
	logic [2:0] wtarget;
	logic [11:0] tc;
	logic [15:0] res16;
	logic [27:0] full_w;
	logic [ENTRY_W-1:0] entry, sgl_head, scn_head;
	logic [2:0] sgl_cnt, scn_cnt;
	logic sgl_ovf, sgl_unf, scn_ovf, scn_unf, sgl_dv, scn_dv;
	logic [NFLAG-1:0] fset, fclr;
	sac_warm_t wmode;

	// Widen a buffer entry to the 32-bit read word
	function automatic logic [31:0] ext(input logic [ENTRY_W-1:0] e, input logic with_id);
		if (with_id) begin
			return {11'h000, e[RES_W +: ID_W], e[RES_W-1:0]};
		end
		return e[ENTRY_W-1] ? {{16{e[RES_W-1]}}, e[RES_W-1:0]} : {16'h0000, e[RES_W-1:0]};
	endfunction

	// Source clock is sampled, never used as a clock: one clock tree, no domain-crossing hazards
	sac_sync #(.W(1)) u_aclk_sync (
		.clk(CLK_SYS),
		.rst(RESET),
		.d(ASYNC_CLK_IN),
		.q(aclk_s)
	);

	sac_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_sgl_fifo (
		.clk(CLK_SYS),
		.rst(RESET),
		.push(sgl_push),
		.din(entry),
		.ovwr(r_q.sctl[M_OVWR]),
		.pop(sgl_pop),
		.head(sgl_head),
		.cnt(sgl_cnt),
		.ovf(sgl_ovf),
		.unf(sgl_unf)
	);

	sac_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_scn_fifo (
		.clk(CLK_SYS),
		.rst(RESET),
		.push(scn_push),
		.din(entry),
		.ovwr(r_q.cctl[M_OVWR]),
		.pop(scn_pop),
		.head(scn_head),
		.cnt(scn_cnt),
		.ovf(scn_ovf),
		.unf(scn_unf)
	);

	always_comb begin
		r_d = r_q;
		en = r_q.ctrl[C_EN];
		wmode = sac_warm_t'(r_q.ctrl[C_WARM +: 2]);
		// Engine ticks: every bus clock, or each sampled rising edge of the source clock
		eng_tick = r_q.ctrl[C_ENG] ? (aclk_s && !r_q.aclk_prev) : 1'b1;
		r_d.aclk_prev = aclk_s;
		sar_tick = eng_tick && (r_q.prescale_field == r_q.ctrl[C_PRESCALE_FIELD +: 7]);
		if (eng_tick) begin
			r_d.prescale_field = sar_tick ? 7'h00 : r_q.prescale_field + 7'h01;
		end
		mc = r_q.cur_scan ? r_q.cctl : r_q.sctl;
		nbits = res_bits(mc[M_RES +: 2]);
		osrsh = 5'(r_q.ctrl[C_OSR +: 4]) + 5'h01;
		ovs_last = !mc[M_OVS] || ((13'(r_q.ocnt) + 13'h0001) == (13'h0001 << osrsh));
		tc = mc[M_DIFF] ? {~r_q.trial[11], r_q.trial[10:0]} : r_q.trial;
		// Result shaping: oversampled to 16 bits, else left or right aligned
		full_w = {r_q.acc, 4'h0};
		sh = mc[M_OVS] ? osrsh : (mc[M_LEFT] ? 5'h00 : 5'(4'(SAR_W) - nbits) + 5'h04);
		res16 = mc[M_DIFF] ? 16'($signed(full_w) >>> sh) : 16'(full_w >> sh);
		entry = {mc[M_DIFF], r_q.cur_chan, res16};
		trip = (r_q.thr[15:0] <= r_q.thr[31:16]) ?
			(res16 >= r_q.thr[15:0] && res16 <= r_q.thr[31:16]) :
			(res16 >= r_q.thr[15:0] || res16 <= r_q.thr[31:16]);
		wtarget = (wmode == WARM_NORMAL || !r_q.warm_done) ? WARM_LONG :
			((wmode == WARM_KEEP) ? 3'h0 : WARM_SHORT);
		nx = next_chan(r_q.mask, {1'b0, r_q.scn_idx});
		jmc = r_q.sctl;
		sgl_push = 1'b0;
		scn_push = 1'b0;
		fset = '0;

		// Register access: zero wait, read data captured in the setup cycle
		wr_acc = PSEL && PENABLE && PWRITE && !r_q.pslverr;
		rd_acc = PSEL && PENABLE && !PWRITE && !r_q.pslverr;
		sgl_pop = rd_acc && (PADDR == OFS_SGL_DATA);
		scn_pop = rd_acc && (PADDR == OFS_SCN_DATA || PADDR == OFS_SCN_DATAX);
		if (PSEL && !PENABLE) begin
			r_d.pslverr = 1'b0;
			case (PADDR)
				OFS_CTRL: r_d.prdata = r_q.ctrl;
				OFS_SGL_CTRL: r_d.prdata = r_q.sctl;
				OFS_SCN_CTRL: r_d.prdata = r_q.cctl;
				OFS_SCN_MASK: r_d.prdata = r_q.mask;
				OFS_CMD: r_d.prdata = 32'h0000_0000;
				OFS_STATUS: r_d.prdata = {17'h00000, scn_cnt, sgl_cnt, r_q.st, r_q.req, r_q.warm_done,
					r_q.scn_act, r_q.sgl_pend, scn_dv, sgl_dv};
				OFS_FLAGS: r_d.prdata = {{(32-NFLAG){1'b0}}, r_q.flags};
				OFS_CMPTHR: r_d.prdata = r_q.thr;
				OFS_SGL_DATA: r_d.prdata = ext(sgl_head, 1'b0);
				OFS_SCN_DATA: r_d.prdata = ext(scn_head, 1'b0);
				OFS_SCN_DATAX: r_d.prdata = ext(scn_head, 1'b1);
				default: begin
					r_d.prdata = 32'h0000_0000;
					r_d.pslverr = 1'b1;
				end
			endcase
		end
		fclr = (wr_acc && PADDR == OFS_FLAGS) ? PWDATA[NFLAG-1:0] : '0;
		if (wr_acc) begin
			case (PADDR)
				OFS_CTRL: r_d.ctrl = PWDATA;
				OFS_SGL_CTRL: r_d.sctl = PWDATA;
				OFS_SCN_CTRL: r_d.cctl = PWDATA;
				OFS_SCN_MASK: r_d.mask = PWDATA;
				OFS_CMPTHR: r_d.thr = PWDATA;
				default: r_d.ctrl = r_q.ctrl;
			endcase
		end

		// Triggers from software or the reflex network
		sgl_trig = TRIG_SINGLE || (wr_acc && PADDR == OFS_CMD && PWDATA[K_SGL_GO]);
		scn_trig = TRIG_SCAN || (wr_acc && PADDR == OFS_CMD && PWDATA[K_SCN_GO]);
		if (en && sgl_trig) begin
			r_d.sgl_pend = 1'b1;
		end
		if (en && scn_trig && !r_q.scn_act) begin
			r_d.scn_act = 1'b1;
			r_d.scn_idx = 5'h00;
		end
		if (wr_acc && PADDR == OFS_CMD && PWDATA[K_SGL_STOP]) begin
			r_d.sgl_pend = 1'b0;
		end
		if (wr_acc && PADDR == OFS_CMD && PWDATA[K_SCN_STOP]) begin
			r_d.scn_act = 1'b0;
		end

		// Engine sequencer
		case (r_q.st)
			ST_IDLE: begin
				if (en && eng_tick) begin
					// A pending single slips in right after a scan sample; otherwise scan goes first
					if (r_q.sgl_pend && (r_q.last_scan || !r_q.scn_act)) begin
						r_d.cur_scan = 1'b0;
						r_d.cur_chan = r_q.sctl[M_POS +: 5];
						r_d.st = ST_WARM;
					end else if (r_q.scn_act && nx[5]) begin
						jmc = r_q.cctl;
						r_d.cur_scan = 1'b1;
						r_d.cur_chan = nx[4:0];
						r_d.st = ST_WARM;
					end else if (r_q.scn_act) begin
						r_d.scn_act = 1'b0;
					end
					r_d.last_scan = 1'b0;
					r_d.ocnt = 12'h000;
					r_d.acc = 24'h000000;
					if (r_d.st == ST_WARM) begin
						if (jmc[M_DIFF] && jmc[M_NEG +: 5] == r_d.cur_chan) begin
							fset[F_PROGERR] = 1'b1;
						end
						if (wtarget == 3'h0) begin
							r_d.st = ST_ACQ;
							r_d.prescale_field = 7'h00;
						end
						r_d.tb = 8'h00;
						r_d.wper = 3'h0;
					end
				end
			end
			ST_WARM: begin
				// Counted on engine ticks, independent of the prescaler
				if (eng_tick) begin
					if (r_q.tb == r_q.ctrl[C_TB +: 8]) begin
						r_d.tb = 8'h00;
						r_d.wper = r_q.wper + 3'h1;
						if (r_q.wper + 3'h1 == wtarget) begin
							r_d.warm_done = 1'b1;
							r_d.st = ST_ACQ;
							// Restart the prescaler so acquisition spans whole conversion clocks
							r_d.prescale_field = 7'h00;
							r_d.acq = 8'h00;
						end
					end else begin
						r_d.tb = r_q.tb + 8'h01;
					end
				end
			end
			ST_ACQ: begin
				if (sar_tick) begin
					if (r_q.acq == mc[M_ACQ +: 8]) begin
						r_d.acq = 8'h00;
						r_d.st = ST_APPROX;
						r_d.trial = SAR_MSB;
						r_d.pos = SAR_MSB;
						r_d.bitc = nbits;
					end else begin
						r_d.acq = r_q.acq + 8'h01;
					end
				end
			end
			ST_APPROX: begin
				// One conversion clock per bit, then one closing cycle
				if (sar_tick) begin
					if (r_q.bitc != 4'h0) begin
						r_d.trial = (ANA_CMP ? r_q.trial : (r_q.trial & ~r_q.pos)) |
							((r_q.bitc != 4'h1) ? (r_q.pos >> 1) : 12'h000);
						r_d.pos = r_q.pos >> 1;
						r_d.bitc = r_q.bitc - 4'h1;
					end else begin
						r_d.acc = r_q.acc + (mc[M_DIFF] ? {{12{tc[11]}}, tc} : {12'h000, tc});
						r_d.ocnt = r_q.ocnt + 12'h001;
						r_d.st = ovs_last ? ST_STORE : ST_ACQ;
					end
				end
			end
			ST_STORE: begin
				r_d.st = ST_IDLE;
				r_d.last_scan = r_q.cur_scan;
				if (r_q.cur_scan) begin
					scn_push = 1'b1;
					fset[F_SCN_CMP] = mc[M_CMP] && trip;
					nx = next_chan(r_q.mask, {1'b0, r_q.cur_chan} + 6'h01);
					if (nx[5]) begin
						r_d.scn_idx = nx[4:0];
					end else begin
						r_d.scn_idx = 5'h00;
						r_d.scn_act = r_q.cctl[M_REP] && r_d.scn_act;
					end
				end else begin
					sgl_push = 1'b1;
					fset[F_SGL_CMP] = mc[M_CMP] && trip;
					r_d.sgl_pend = r_d.sgl_pend && (r_q.sctl[M_REP] || sgl_trig);
				end
			end
			default: r_d.st = ST_IDLE;
		endcase

		// Disabling aborts everything and forces a fresh warm-up
		if (!en) begin
			r_d.st = ST_IDLE;
			r_d.sgl_pend = 1'b0;
			r_d.scn_act = 1'b0;
			r_d.warm_done = 1'b0;
		end

		// Watermark levels drive DMA and set sticky flags
		sgl_dv = sgl_cnt >= ({1'b0, r_q.sctl[M_DVL +: 2]} + 3'h1);
		scn_dv = scn_cnt >= ({1'b0, r_q.cctl[M_DVL +: 2]} + 3'h1);
		fset[F_SGL_DV] = sgl_dv;
		fset[F_SCN_DV] = scn_dv;
		fset[F_SGL_OVF] = sgl_ovf;
		fset[F_SCN_OVF] = scn_ovf;
		fset[F_SGL_UNF] = sgl_unf;
		fset[F_SCN_UNF] = scn_unf;
		fset[F_OVERV] = OVERVOLT && !r_q.ov_prev;
		fset[F_PROGERR] = fset[F_PROGERR] || (PORT_CONFLICT && !r_q.conf_prev);
		r_d.ov_prev = OVERVOLT;
		r_d.conf_prev = PORT_CONFLICT;
		// Set wins over a simultaneous write-one clear
		r_d.flags = (r_q.flags & ~fclr) | fset;

		// Clock request: per conversion only for on-demand with normal warm mode
		if (en && r_q.ctrl[C_ENG]) begin
			r_d.req = (r_q.ctrl[C_POL] && wmode == WARM_NORMAL) ?
				(r_d.sgl_pend || r_d.scn_act || r_d.st != ST_IDLE) : 1'b1;
		end else begin
			r_d.req = 1'b0;
		end
		r_d.samp = (r_d.st == ST_ACQ);
		r_d.power = en && (r_d.st != ST_IDLE || wmode == WARM_KEEP);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			r_q <= '0;
			r_q.ctrl <= CTRL_RST;
			r_q.sctl <= MCTL_RST;
			r_q.cctl <= MCTL_RST;
			r_q.mask <= MASK_RST;
			r_q.thr <= THR_RST;
			r_q.st <= ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	// Zero-wait slave; error only on unmapped offsets
	assign PREADY = 1'b1;
	assign PRDATA = r_q.prdata;
	assign PSLVERR = r_q.pslverr && PSEL && PENABLE;
	assign ASYNC_CLK_REQ = r_q.req;
	assign ANA_POWER = r_q.power;
	assign ANA_SAMPLE = r_q.samp;
	assign ANA_DIFF = mc[M_DIFF];
	assign ANA_POS_SEL = r_q.cur_chan;
	assign ANA_NEG_SEL = mc[M_NEG +: 5];
	assign SAR_TRIAL = r_q.trial;
	assign DMA_REQ_SINGLE = sgl_dv;
	assign DMA_REQ_SCAN = scn_dv;
endmodule

/* File: bench/sac_checker.sv */
// Concurrent checks on the converter control pins
`timescale 1ns/1ps
module sac_checker import sac_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TRIG_SINGLE,
	input wire logic TRIG_SCAN,
	input wire logic ASYNC_CLK_REQ,
	input wire logic ANA_POWER,
	input wire logic ANA_SAMPLE
);
	logic [31:0] ctrl_q;
	logic [3:0] age_q;
	logic [15:0] samp_q;
	logic [15:0] prescale_field_f;
	logic wr_ctrl;
	logic on_demand;
	// Shadow control word, since the pins alone do not show the mode
	assign wr_ctrl = PSEL && PENABLE && PWRITE && PADDR == OFS_CTRL;
	assign on_demand = ctrl_q[C_ENG] && ctrl_q[C_POL] && ctrl_q[C_WARM +: 2] == 2'h0;
	assign prescale_field_f = {9'h0, ctrl_q[C_PRESCALE_FIELD +: 7]} + 16'h1;
	// Age of the last control write and width of the sample pulse
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ctrl_q <= CTRL_RST;
			age_q <= 4'h0;
			samp_q <= 16'h0;
		end else begin
			ctrl_q <= wr_ctrl ? PWDATA : ctrl_q;
			age_q <= wr_ctrl ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
			samp_q <= ANA_SAMPLE ? samp_q + 16'h1 : 16'h0;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	sequence s_access;
		PSEL && PENABLE;
	endsequence
	sequence s_single_go;
		s_access ##0 (PWRITE && PADDR == OFS_CMD && PWDATA[K_SGL_GO] && ctrl_q[C_EN] && !ctrl_q[C_ENG]);
	endsequence
	AST_READY: assert property (s_access |-> PREADY)
		else $error("ready missing in access phase");
	AST_ERR_PHASE: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("error response outside access phase");
	AST_ERR_UNMAPPED: assert property (s_access ##0 PADDR > OFS_SCN_DATAX |-> PSLVERR)
		else $error("unmapped access not refused");
	AST_OK_MAPPED: assert property (s_access ##0 (PADDR <= OFS_SCN_DATAX && PADDR[1:0] == 2'h0) |-> !PSLVERR)
		else $error("mapped access refused");
	AST_REQ_SYNC: assert property (!ctrl_q[C_ENG] && age_q > 4'h7 |-> !ASYNC_CLK_REQ)
		else $error("clock request in synchronous mode");
	AST_REQ_POWER: assert property (ctrl_q[C_ENG] && $rose(ANA_POWER) |-> ASYNC_CLK_REQ)
		else $error("engine started without source clock");
	AST_REQ_DEMAND: assert property (on_demand && $fell(ANA_POWER) && !TRIG_SINGLE && !TRIG_SCAN |-> ##[1:8] !ASYNC_CLK_REQ)
		else $error("on-demand request not withdrawn");
	AST_REQ_HOLD: assert property (ctrl_q[C_EN] && ctrl_q[C_ENG] && !on_demand && age_q > 4'h7 |-> ASYNC_CLK_REQ)
		else $error("held clock request missing");
	AST_ACQ_STEPS: assert property (!ctrl_q[C_ENG] && $fell(ANA_SAMPLE) |-> samp_q != 16'h0 && samp_q % prescale_field_f == 16'h0)
		else $error("acquisition not whole conversion clocks");
	AST_GO_POWER: assert property (s_single_go |-> ##[1:16] ANA_POWER)
		else $error("start command did not power the converter");
endmodule
bind sac_top sac_checker u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_SINGLE(TRIG_SINGLE),
	.TRIG_SCAN(TRIG_SCAN), .ASYNC_CLK_REQ(ASYNC_CLK_REQ), .ANA_POWER(ANA_POWER), .ANA_SAMPLE(ANA_SAMPLE));

/* File: bench/sac_partner.sv */
// Clock manager and analog input model on the far side of the converter
`timescale 1ns/1ps
module sac_partner #(
	parameter int HALF_NS = 12,
	parameter int START_NS = 40
) (
	input wire logic clk,
	input wire logic req,
	input wire logic power,
	input wire logic [11:0] trial,
	input wire logic [4:0] pos_sel,
	input wire logic [11:0] lvl_base,
	output logic async_clk,
	output logic cmp
);
	logic junk_q = 1'b0;
	logic [11:0] lvl;
	// Oscillator starts late after a request and halts when it is withdrawn
	initial begin
		async_clk = 1'b0;
		forever begin
			wait (req === 1'b1);
			#(START_NS);
			while (req === 1'b1) begin
				#(HALF_NS) async_clk = 1'b1;
				#(HALF_NS) async_clk = 1'b0;
			end
		end
	end
	// Unpowered comparator output is garbage, never the last answer
	always @(posedge clk) junk_q <= ~junk_q;
	assign lvl = lvl_base + {3'h0, pos_sel, 4'h0};
	assign cmp = power ? (lvl >= trial) : junk_q;
endmodule

/* File: bench/tb_sar_adc_clocking_and_control.sv */
// Register-level testbench of the converter control block
`timescale 1ns/1ps
module tb_sar_adc_clocking_and_control import sac_pkg::*;;
	logic clk, rst, psel, pen, pwr, perr, pslverr, pready, trig_s, trig_c, conf, ovv;
	logic areq, apow, asamp, dma_s, dma_c, aclk, acmp, adiff;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [11:0] trial, lvl;
	logic [4:0] pos, aneg;
	int miscompares, samples_checked, n;
	sac_top u_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ASYNC_CLK_IN(aclk),
		.TRIG_SINGLE(trig_s), .TRIG_SCAN(trig_c), .ANA_CMP(acmp), .PORT_CONFLICT(conf), .OVERVOLT(ovv),
		.ASYNC_CLK_REQ(areq), .ANA_POWER(apow), .ANA_SAMPLE(asamp), .ANA_DIFF(adiff), .ANA_POS_SEL(pos),
		.ANA_NEG_SEL(aneg), .SAR_TRIAL(trial), .DMA_REQ_SINGLE(dma_s), .DMA_REQ_SCAN(dma_c));
	sac_partner u_far (.clk(clk), .req(areq), .power(apow), .trial(trial), .pos_sel(pos), .lvl_base(lvl),
		.async_clk(aclk), .cmp(acmp));
	// 125 MHz system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One bus transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
		apb(1'b0, a, 32'h0);
		chk(nm, r & m, exp);
	endtask
	// Counts settled cycles until the chosen data request rises
	task automatic wait_dma(input logic scan);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((scan ? dma_c : dma_s) !== 1'b1 && n < 3000);
		chk("dma wait", {31'h0, scan ? dma_c : dma_s}, 32'h1);
	endtask
	task automatic req_is(input string nm, input logic exp);
		repeat (20) @(negedge clk);
		chk(nm, {31'h0, areq}, {31'h0, exp});
	endtask
	initial begin
		{rst, psel, pen, pwr, trig_s, trig_c, conf, ovv} = 8'h80;
		paddr = 8'h00;
		pwdata = 32'h0;
		lvl = 12'h123;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CTRL, "ctrl", CTRL_RST);
		rd(OFS_SCN_MASK, "mask", MASK_RST);
		rd(OFS_CMPTHR, "thr", THR_RST);
		rd(OFS_FLAGS, "flags", 32'h0);
		rd(8'h30, "unmapped", 32'h0);
		chk("unmapped err", {31'h0, perr}, 32'h1);
		// Prescale 8 keeps the conversion clock at 15.6 MHz
		wr_all();
		wait_dma(1'b0);
		chk("single time", 32'(n >= 130 && n <= 140), 32'h1);
		rd(OFS_SGL_DATA, "single", 32'h153);
		@(negedge clk);
		chk("dma single", {31'h0, dma_s}, 32'h0);
		apb(1'b0, OFS_SGL_DATA, 32'h0);
		rd(OFS_FLAGS, "flags", 32'h51);
		apb(1'b1, OFS_FLAGS, 32'h3FF);
		rd(OFS_FLAGS, "flags clear", 32'h0);
		// Repeat until the buffer refuses, then drain it
		apb(1'b1, OFS_SGL_CTRL, 32'h0180_0109);
		apb(1'b1, OFS_CMD, 32'h1);
		repeat (800) @(posedge clk);
		apb(1'b1, OFS_CMD, 32'h4);
		repeat (200) @(posedge clk);
		rd(OFS_STATUS, "full", 32'h800, 32'hE00);
		rd(OFS_FLAGS, "overflow", 32'h4, 32'h4);
		for (int i = 0; i < 4; i++) rd(OFS_SGL_DATA, "drain", 32'h153);
		rd(OFS_STATUS, "empty", 32'h0, 32'hE00);
		// Two-channel left-aligned scan with channel tags
		apb(1'b1, OFS_SCN_MASK, 32'h5);
		apb(1'b1, OFS_SCN_CTRL, 32'h0001_0140);
		apb(1'b1, OFS_CMD, 32'h2);
		wait_dma(1'b1);
		rd(OFS_SCN_DATAX, "scan 0", 32'h0000_1230);
		rd(OFS_SCN_DATAX, "scan 2", 32'h0002_1430);
		@(posedge clk);
		conf <= 1'b1;
		ovv <= 1'b1;
		repeat (3) @(posedge clk);
		conf <= 1'b0;
		ovv <= 1'b0;
		rd(OFS_FLAGS, "events", 32'h300, 32'h300);
		// Asynchronous engine clock at 41.7 MHz, prescale 3
		// Oversampling by two on the single channel, negative select 1
		apb(1'b1, OFS_SGL_CTRL, 32'h0184_0104);
		apb(1'b1, OFS_CTRL, 32'h0000_1047);
		req_is("req idle", 1'b0);
		@(posedge clk);
		trig_s <= 1'b1;
		@(posedge clk);
		trig_s <= 1'b0;
		wait_dma(1'b0);
		rd(OFS_SGL_DATA, "async single", 32'h1530);
		chk("input sel", {26'h0, adiff, aneg}, 32'h1);
		req_is("req dropped", 1'b0);
		apb(1'b1, OFS_CTRL, 32'h0000_1043);
		req_is("req held", 1'b1);
		apb(1'b1, OFS_CTRL, 32'h0000_1041);
		req_is("req sync", 1'b0);
		end_of_test();
	end
	task automatic wr_all();
		apb(1'b1, OFS_CMPTHR, 32'h0FFF_0010);
		apb(1'b1, OFS_CTRL, 32'h0000_10E1);
		apb(1'b1, OFS_SGL_CTRL, 32'h0180_0108);
		apb(1'b1, OFS_CMD, 32'h1);
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule
